// *** rtl/ext_bus_defines.svh ***
// Purpose: Timing counts, field widths and reset values of the external bus controller.
// Assumes: One CPU clock; the output clock runs at half its rate.
// Notes:   Definitions only.
`ifndef EXT_BUS_DEFINES_SVH
`define EXT_BUS_DEFINES_SVH

`define MCW_W          4
`define CS_NUM         5
`define CS_SEL_W       3
`define SYNC_STAGES    3
`define CS_IDLE_N      5'h1F
`define PIN_IDLE       1'h1
`define MCW_ONE        4'h1
`define MCW_ZERO       4'h0

`endif

// *** rtl/ext_bus_pkg.sv ***
// Purpose: Types shared by the external bus controller and its helpers.
// Assumes: The defines header is included first.
// Notes:   Holds types only.
`include "ext_bus_defines.svh"

package ext_bus_pkg;

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_ADDR,
      ST_WAIT,
      ST_READY,
      ST_MUXW,
      ST_TRIW,
      ST_GRANT,
      ST_REGAIN
   } bus_state_e;

   typedef logic [`MCW_W-1:0]    mcw_t;
   typedef logic [`CS_NUM-1:0]   cs_vec_t;
   typedef logic [`CS_SEL_W-1:0] cs_sel_t;

endpackage : ext_bus_pkg

// *** rtl/wait_tmr_if.sv ***
// Purpose: Carries load, step and end signals between bus sequencer and wait timer.
// Assumes: Both ends run on clk_sys.
// Notes:   The sequencer drives load and step; the timer reports the last wait state.
`timescale 1ns/1ps

interface wait_tmr_if;
   import ext_bus_pkg::*;

   logic load;
   mcw_t init;
   logic step;
   logic last;

   modport ctl (output load, output init, output step, input last);
   modport tmr (input load, input init, input step, output last);

endinterface : wait_tmr_if

// *** rtl/pin_sync.sv ***
// Purpose: Brings asynchronous pin levels into the clk_sys domain.
// Assumes: Inputs idle high.
// Notes:   The output changes only once the second and third stages agree.
`timescale 1ns/1ps
`include "ext_bus_defines.svh"

module pin_sync #(
   parameter int W = 2
) (
   // Clock and reset
   input  wire logic         clk_sys,
   input  wire logic         srst,
   // Pin side
   input  wire logic [W-1:0] pin_in,
   // Synchronised side
   output logic      [W-1:0] lvl_out
);

   logic [W-1:0] s1_r, s2_r, s3_r, lvl_r;
   logic [W-1:0] lvl_nxt;

   always_comb begin
      lvl_nxt = lvl_r;
      for (int i = 0; i < W; i++) begin
         if (s2_r[i] == s3_r[i]) begin
            lvl_nxt[i] = s3_r[i];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         s1_r  <= {W{`PIN_IDLE}};
         s2_r  <= {W{`PIN_IDLE}};
         s3_r  <= {W{`PIN_IDLE}};
         lvl_r <= {W{`PIN_IDLE}};
      end else begin
         s1_r  <= pin_in;
         s2_r  <= s1_r;
         s3_r  <= s2_r;
         lvl_r <= lvl_nxt;
      end
   end

   assign lvl_out = lvl_r;

endmodule : pin_sync

// *** rtl/wait_tmr.sv ***
// Purpose: Counts the programmed memory-cycle wait states of one bus cycle.
// Assumes: The sequencer steps it once per output clock cycle.
// Notes:   last is high while the final wait state is running.
`timescale 1ns/1ps
`include "ext_bus_defines.svh"

module wait_tmr
   import ext_bus_pkg::*;
(
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic srst,
   // Sequencer side
   wait_tmr_if.tmr   tm
);

   mcw_t cnt_r;
   mcw_t cnt_nxt;

   always_comb begin
      cnt_nxt = cnt_r;
      if (tm.load) begin
         cnt_nxt = tm.init;
      end else if (tm.step && cnt_r != `MCW_ZERO) begin
         cnt_nxt = cnt_r - `MCW_ONE;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         cnt_r <= `MCW_ZERO;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   assign tm.last = (cnt_r == `MCW_ONE);

endmodule : wait_tmr

// *** rtl/ext_bus_ctl.sv ***
// Purpose: External bus cycle sequencer with ready wait states and hold arbitration.
// Assumes: Pins ready_n_in and hold_n_in are asynchronous; CPU side is on clk_sys.
// Notes:   The output clock is clk_sys divided by two; the state machine moves at its rise, an undelayed strobe starts at its fall.
`timescale 1ns/1ps
`include "ext_bus_defines.svh"

module ext_bus_ctl
   import ext_bus_pkg::*;
(
   // Clock and reset
   input  wire logic          clk_sys,
   input  wire logic          srst,
   // CPU bus controller side
   input  wire logic          cyc_req,
   input  wire logic          cyc_write,
   input  wire cs_sel_t       cyc_cs,
   output logic               cyc_done,
   output logic               bus_released,
   // Configuration
   input  wire logic          mux_mode,
   input  wire logic          tristate_wait_state,
   input  wire logic          rw_delay_en,
   input  wire mcw_t          memory_cycle_wait_count,
   // External bus pins
   input  wire logic          ready_n_in,
   input  wire logic          hold_n_in,
   output logic               system_clock_output,
   output cs_vec_t            chip_select_out_n,
   output logic               chip_select_oe,
   output logic               rd_n_out,
   output logic               wr_n_out,
   output logic               strobe_oe,
   output logic               hold_grant_out,
   output logic               bus_request_out_n
);

   bus_state_e state_r, state_nxt;
   logic       clk_r, clk_nxt;
   logic       wr_r, wr_nxt;
   cs_sel_t    sel_r, sel_nxt;
   cs_vec_t    cs_n_r, cs_n_nxt;
   logic       rd_n_r, rd_n_nxt;
   logic       wr_n_r, wr_n_nxt;
   logic       oe_r, oe_nxt;
   logic       grant_r, grant_nxt;
   logic       bus_request_out_n_r, bus_request_out_n_nxt;
   logic       done_r, done_nxt;
   logic [1:0] sync_lvl;
   logic       ready_n_s;
   logic       hold_n_s;
   logic       tick;
   logic       strobe_go;

   wait_tmr_if tmr_bus ();

   // Three-stage synchronisers guard against a ready that misses setup.
   pin_sync #(
      .W       (2)
   ) u_sync (
      .clk_sys (clk_sys),
      .srst    (srst),
      .pin_in  ({hold_n_in, ready_n_in}),
      .lvl_out (sync_lvl)
   );

   wait_tmr u_tmr (
      .clk_sys (clk_sys),
      .srst    (srst),
      .tm      (tmr_bus.tmr)
   );

   assign ready_n_s = sync_lvl[0];
   assign hold_n_s  = sync_lvl[1];

   // The edge that follows a low output clock is its rising edge.
   assign tick = ~clk_r;

   function automatic cs_vec_t cs_decode(input cs_sel_t sel);
      cs_vec_t v;
      v = `CS_IDLE_N;
      if (sel < `CS_NUM) begin
         v[sel] = 1'b0;
      end
      return v;
   endfunction : cs_decode

   // Strobe goes active at mid-cycle of the address phase when no delay is set.
   assign strobe_go = (state_r == ST_ADDR) && clk_r && !rw_delay_en;

   always_comb begin
      state_nxt  = state_r;
      clk_nxt    = ~clk_r;
      wr_nxt     = wr_r;
      sel_nxt    = sel_r;
      cs_n_nxt   = cs_n_r;
      rd_n_nxt   = rd_n_r;
      wr_n_nxt   = wr_n_r;
      oe_nxt     = oe_r;
      grant_nxt  = grant_r;
      bus_request_out_n_nxt = bus_request_out_n_r;
      done_nxt   = 1'b0;
      tmr_bus.load = 1'b0;
      tmr_bus.init = memory_cycle_wait_count;
      tmr_bus.step = 1'b0;
      if (strobe_go) begin
         rd_n_nxt = wr_r;
         wr_n_nxt = ~wr_r;
      end
      if (tick) begin
         unique case (state_r)
            ST_IDLE: begin
               if (!hold_n_s) begin
                  // Only reached between cycles, so the running one has ended.
                  state_nxt = ST_GRANT;
                  oe_nxt    = 1'b0;
                  grant_nxt = 1'b1;
                  cs_n_nxt  = `CS_IDLE_N;
               end else if (cyc_req) begin
                  state_nxt = ST_ADDR;
                  wr_nxt    = cyc_write;
                  sel_nxt   = cyc_cs;
                  cs_n_nxt  = cs_decode(cyc_cs);
               end
            end
            ST_ADDR: begin
               // A delayed strobe starts with the first wait or ready phase.
               rd_n_nxt = wr_r;
               wr_n_nxt = ~wr_r;
               if (memory_cycle_wait_count != `MCW_ZERO) begin
                  state_nxt    = ST_WAIT;
                  tmr_bus.load = 1'b1;
               end else begin
                  state_nxt = ST_READY;
               end
            end
            ST_WAIT: begin
               // Programmed wait states run before ready is looked at.
               tmr_bus.step = 1'b1;
               if (tmr_bus.last) begin
                  state_nxt = ST_READY;
               end
            end
            ST_READY: begin
               if (!ready_n_s) begin
                  // Ready low ends the cycle and lifts the strobe.
                  done_nxt = 1'b1;
                  rd_n_nxt = 1'b1;
                  wr_n_nxt = 1'b1;
                  cs_n_nxt = `CS_IDLE_N;
                  if (mux_mode) begin
                     state_nxt = ST_MUXW;
                  end else if (tristate_wait_state) begin
                     state_nxt = ST_TRIW;
                  end else begin
                     state_nxt = ST_IDLE;
                  end
               end
               // Ready high keeps this state: one ready-controlled wait state.
            end
            ST_MUXW: begin
               state_nxt = tristate_wait_state ? ST_TRIW : ST_IDLE;
            end
            ST_TRIW: begin
               state_nxt = ST_IDLE;
            end
            ST_GRANT: begin
               if (hold_n_s) begin
                  // Regain starts on hold going high, whether or not requested.
                  state_nxt  = ST_REGAIN;
                  grant_nxt  = 1'b0;
                  bus_request_out_n_nxt = 1'b1;
               end else if (grant_r && cyc_req) begin
                  bus_request_out_n_nxt = 1'b0;
               end
            end
            ST_REGAIN: begin
               // Bus lines are driven again before any new cycle starts.
               oe_nxt    = 1'b1;
               state_nxt = ST_IDLE;
            end
            default: begin
               state_nxt = ST_IDLE;
            end
         endcase
      end
   end

   // All arbitration outputs move only at output clock rise.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state_r  <= ST_IDLE;
         clk_r    <= 1'b0;
         wr_r     <= 1'b0;
         sel_r    <= '0;
         cs_n_r   <= `CS_IDLE_N;
         rd_n_r   <= 1'b1;
         wr_n_r   <= 1'b1;
         oe_r     <= 1'b1;
         grant_r  <= 1'b0;
         bus_request_out_n_r <= 1'b1;
         done_r   <= 1'b0;
      end else begin
         state_r  <= state_nxt;
         clk_r    <= clk_nxt;
         wr_r     <= wr_nxt;
         sel_r    <= sel_nxt;
         cs_n_r   <= cs_n_nxt;
         rd_n_r   <= rd_n_nxt;
         wr_n_r   <= wr_n_nxt;
         oe_r     <= oe_nxt;
         grant_r  <= grant_nxt;
         bus_request_out_n_r <= bus_request_out_n_nxt;
         done_r   <= done_nxt;
      end
   end

   assign system_clock_output = clk_r;
   assign chip_select_out_n   = cs_n_r;
   assign chip_select_oe      = oe_r;
   assign strobe_oe           = oe_r;
   assign rd_n_out            = rd_n_r;
   assign wr_n_out            = wr_n_r;
   assign hold_grant_out      = grant_r;
   assign bus_request_out_n   = bus_request_out_n_r;
   assign cyc_done            = done_r;
   assign bus_released        = grant_r;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);

   a_ready_wait_ext: assert property (
      state_r == ST_READY && tick && ready_n_s |=> state_r == ST_READY && !done_r)
      else $error("ready high did not extend the cycle");

   a_ready_ends_cyc: assert property (
      state_r == ST_READY && tick && !ready_n_s |=> done_r && state_r != ST_READY
         && rd_n_r && wr_n_r)
      else $error("ready low did not end the cycle");

   a_mux_wait_add: assert property (
      state_r == ST_READY && tick && !ready_n_s && mux_mode |=> state_r == ST_MUXW [*2])
      else $error("multiplex wait state missing");

   a_mux_tri_gap: assert property (
      state_r == ST_READY && tick && !ready_n_s && mux_mode && tristate_wait_state
      |=> state_r == ST_MUXW [*2] ##1 state_r == ST_TRIW [*2] ##1 state_r == ST_IDLE)
      else $error("gap is not two output clocks");

   a_demux_no_gap: assert property (
      state_r == ST_READY && tick && !ready_n_s && !mux_mode && !tristate_wait_state
      |=> state_r == ST_IDLE)
      else $error("demultiplexed gap is not zero");

   a_wait_no_sample: assert property (
      state_r == ST_WAIT && tick && !tmr_bus.last |=> state_r == ST_WAIT && !done_r)
      else $error("wait states cut short");

   a_strobe_delay: assert property (
      state_r == ST_ADDR && rw_delay_en |-> rd_n_r && wr_n_r)
      else $error("strobe started despite read/write delay");

   a_grant_at_idle: assert property (
      $rose(grant_r) |-> $past(state_r) == ST_IDLE && !oe_r)
      else $error("grant given inside a bus cycle");

   a_cs_released: assert property (
      grant_r |-> !chip_select_oe)
      else $error("chip selects driven while bus released");

   a_bus_request_out_late: assert property (
      $fell(bus_request_out_n_r) |-> $past(grant_r, 2))
      else $error("bus request before cycle after grant");

   a_regain_hold: assert property (
      $fell(grant_r) |-> $past(hold_n_s) && bus_request_out_n_r)
      else $error("regain began without hold high");

   a_drive_first: assert property (
      state_r == ST_ADDR |-> oe_r && !grant_r)
      else $error("cycle started with bus undriven");

   a_cs_match_sel: assert property (
      state_r == ST_ADDR |-> cs_n_r == cs_decode(sel_r))
      else $error("chip selects do not match the selected range");

   a_clk_rise_upd: assert property (
      $changed(grant_r) || $changed(bus_request_out_n_r) |-> clk_r)
      else $error("arbitration output moved off the rising edge");

   c_ready_ext:  cover property (state_r == ST_READY && tick && ready_n_s);
   c_hold_cycle: cover property ($rose(grant_r) ##[1:200] $fell(grant_r));
   c_mux_tri:    cover property (state_r == ST_MUXW ##2 state_r == ST_TRIW);
   c_bus_request_out:       cover property ($fell(bus_request_out_n_r));

endmodule : ext_bus_ctl

// *** dv/far_side_model.sv ***
// Purpose: Far side of the external bus: a responder answering with ready, and a second master.
// Assumes: Pins change just after clk_sys rises.
// Notes:   Ready delay and hold request are commanded by the bench.
`timescale 1ns/1ps

module far_side_model (
   // Clock
   input  wire logic       clk_sys,
   // Strobes from the controller
   input  wire logic       rd_n_out,
   input  wire logic       wr_n_out,
   input  wire logic       strobe_oe,
   // Commands from the bench
   input  wire logic [2:0] ready_dly,
   input  wire logic       hold_req,
   // Pins towards the controller
   output logic            ready_n_in,
   output logic            hold_n_in
);
   logic [5:0] age_r;
   logic       cmd_low;

   assign cmd_low = strobe_oe && !(rd_n_out && wr_n_out);

   initial begin
      ready_n_in = 1'h1;
      hold_n_in  = 1'h1;
      age_r      = 6'h00;
   end

   // Ready drops a chosen number of clocks into the command and is only released after the
   // command's trailing edge, so its low time always covers the synchroniser.
   always @(posedge clk_sys) begin
      if (!cmd_low) begin
         age_r <= 6'h00;
      end else if (age_r != 6'h3F) begin
         age_r <= age_r + 6'h01;
      end
      ready_n_in <= !(cmd_low && age_r >= {3'h0, ready_dly});
      hold_n_in  <= !hold_req;
   end
endmodule : far_side_model

// *** dv/ext_bus_ready_and_hold_arbitration_bench.sv ***
// Purpose: Self-checking bench for the external bus controller.
// Assumes: Far side model answers ready and requests hold on command.
// Notes:   The driver queues expected strobe and select patterns; a monitor checks them.
`timescale 1ns/1ps
`include "ext_bus_defines.svh"

module ext_bus_ready_and_hold_arbitration_bench
   import ext_bus_pkg::*;
;
   logic        clk_sys, srst, cyc_req, cyc_write, cyc_done, bus_released;
   logic        mux_mode, tristate_wait_state, rw_delay_en, hold_req;
   logic        ready_n_in, hold_n_in, system_clock_output, chip_select_oe;
   logic        rd_n_out, wr_n_out, strobe_oe, hold_grant_out, bus_request_out_n;
   cs_sel_t     cyc_cs;
   mcw_t        memory_cycle_wait_count;
   cs_vec_t     chip_select_out_n;
   logic [2:0]  ready_dly;
   logic [6:0]  notes[$];
   logic [6:0]  note;
   logic [31:0] rng_r;
   int          mismatches, checks_done, gap_min, cs_cnt, rdy_cnt, hold_cnt, grant_age, gap_cnt;
   logic        str_prev, grant_prev, bus_request_out_prev, cs_prev, gap_armed, str_low, cs_act;

   ext_bus_ctl u_dut (.clk_sys(clk_sys), .srst(srst), .cyc_req(cyc_req),
      .cyc_write(cyc_write), .cyc_cs(cyc_cs), .cyc_done(cyc_done),
      .bus_released(bus_released), .mux_mode(mux_mode),
      .tristate_wait_state(tristate_wait_state), .rw_delay_en(rw_delay_en),
      .memory_cycle_wait_count(memory_cycle_wait_count), .ready_n_in(ready_n_in),
      .hold_n_in(hold_n_in), .system_clock_output(system_clock_output),
      .chip_select_out_n(chip_select_out_n), .chip_select_oe(chip_select_oe),
      .rd_n_out(rd_n_out), .wr_n_out(wr_n_out), .strobe_oe(strobe_oe),
      .hold_grant_out(hold_grant_out), .bus_request_out_n(bus_request_out_n));

   far_side_model u_far (.clk_sys(clk_sys), .rd_n_out(rd_n_out), .wr_n_out(wr_n_out),
      .strobe_oe(strobe_oe), .ready_dly(ready_dly), .hold_req(hold_req),
      .ready_n_in(ready_n_in), .hold_n_in(hold_n_in));

   initial begin
      clk_sys = 1'h0;
      forever #50 clk_sys = ~clk_sys;
   end

   task automatic tally_and_finish();
      $display("Checks %0d, mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : tally_and_finish

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check

   task automatic ok(input logic c);
      check(16'(c), 16'h1);
   endtask : ok

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] v;
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction : xs

   function automatic logic [6:0] note_of(input logic [2:0] idx, input logic wr);
      cs_vec_t cs;
      cs = (idx < 3'h5) ? ~(5'h01 << idx) : `CS_IDLE_N;
      return {wr, !wr, cs};
   endfunction : note_of

   function automatic logic sig_of(input int w);
      case (w)
         0: return cyc_done;
         1: return hold_grant_out;
         default: return rd_n_out && wr_n_out;
      endcase
   endfunction : sig_of

   // Every wait is bounded; running out ends the run as a failure.
   task automatic wait_sig(input int w, input logic lvl);
      int n;
      n = 0;
      do begin
         @(negedge clk_sys);
         n++;
      end while (sig_of(w) !== lvl && n < 400);
      if (n >= 400) begin
         mismatches++;
         $display("Error at %0t: wait ran out", $time);
         tally_and_finish();
      end
   endtask : wait_sig

   task automatic run_cycle(input logic [31:0] r, input logic burst);
      logic [2:0] idx;
      idx = burst ? {1'h0, r[1:0]} : r[2:0];
      @(posedge clk_sys);
      mux_mode <= r[3];
      tristate_wait_state <= r[4];
      rw_delay_en <= r[5];
      memory_cycle_wait_count <= r[9:6];
      ready_dly <= r[12:10];
      cyc_write <= r[13];
      cyc_cs <= idx;
      gap_min = burst ? 2 * (int'(r[3]) + int'(r[4])) : -1;
      notes.push_back(note_of(idx, r[13]));
      if (burst) notes.push_back(note_of(idx, r[13]));
      @(posedge clk_sys);
      cyc_req <= 1'h1;
      wait_sig(0, 1'h1);
      if (burst) wait_sig(0, 1'h1);
      @(posedge clk_sys);
      cyc_req <= 1'h0;
   endtask : run_cycle

   initial begin
      {cyc_req, cyc_write, mux_mode, tristate_wait_state, rw_delay_en, hold_req} = 6'h00;
      cyc_cs = 3'h0;
      memory_cycle_wait_count = 4'h0;
      ready_dly = 3'h0;
      mismatches = 0;
      checks_done = 0;
      gap_min = -1;
      rng_r = 32'h40;
      srst = 1'h1;
      repeat (6) @(posedge clk_sys);
      srst <= 1'h0;
      repeat (3) @(posedge clk_sys);
      for (int i = 0; i < 20; i++) begin
         rng_r = xs(rng_r);
         run_cycle(rng_r, i % 3 == 2);
      end
      // Hold arrives mid-cycle while a further cycle is pending behind it.
      @(posedge clk_sys);
      cyc_cs <= 3'h2;
      ready_dly <= 3'h6;
      gap_min = -1;
      notes.push_back(note_of(3'h2, cyc_write));
      notes.push_back(note_of(3'h2, cyc_write));
      @(posedge clk_sys);
      cyc_req <= 1'h1;
      wait_sig(2, 1'h0);
      @(posedge clk_sys);
      hold_req <= 1'h1;
      wait_sig(0, 1'h1);
      wait_sig(1, 1'h1);
      repeat (20) @(posedge clk_sys);
      hold_req <= 1'h0;
      wait_sig(0, 1'h1);
      @(posedge clk_sys);
      cyc_req <= 1'h0;
      // The other master withdraws hold without being asked.
      hold_req <= 1'h1;
      wait_sig(1, 1'h1);
      repeat (5) @(posedge clk_sys);
      hold_req <= 1'h0;
      wait_sig(1, 1'h0);
      repeat (4) @(posedge clk_sys);
      ok(notes.size() == 0);
      tally_and_finish();
   end

   always @(negedge clk_sys) begin
      str_low = !(rd_n_out && wr_n_out);
      cs_act = chip_select_out_n !== `CS_IDLE_N;
      if (srst) begin
         {str_prev, grant_prev, cs_prev, gap_armed} = 4'h0;
         bus_request_out_prev = 1'h1;
      end else begin
         if (str_low && !str_prev) begin
            ok(notes.size() != 0);
            note = notes.pop_front();
            check(16'({rd_n_out, wr_n_out, chip_select_out_n}), 16'(note));
            check(16'({chip_select_oe, strobe_oe}), 16'h3);
            if (cs_act) check(16'(cs_cnt), 16'(1 + rw_delay_en));
         end
         if (!str_low && str_prev) begin
            ok(rdy_cnt >= 3);
            if (cs_cnt > 0) ok(cs_cnt >= 4 + 2 * int'(memory_cycle_wait_count));
         end
         if (cs_act && !cs_prev && gap_armed) begin
            check(16'(gap_cnt), 16'(gap_min + 1));
            gap_armed = 1'h0;
         end
         if (hold_grant_out && !grant_prev) begin
            check(16'({bus_released, chip_select_out_n, rd_n_out, wr_n_out}), 16'hFF);
            ok(system_clock_output);
            grant_age = 1;
         end
         if (hold_grant_out === 1'h1 && chip_select_oe !== 1'h0) ok(1'h0);
         if (!hold_grant_out && grant_prev) begin
            ok(hold_cnt >= 3);
            check(16'(bus_request_out_n), 16'h1);
            ok(system_clock_output);
         end
         if (!bus_request_out_n && bus_request_out_prev) begin
            ok(hold_grant_out && grant_age >= 2);
            ok(system_clock_output);
         end
         gap_cnt = cyc_done ? 0 : gap_cnt + 1;
         if (cyc_done) gap_armed = gap_min >= 0 && notes.size() != 0;
      end
      cs_cnt = cs_act ? cs_cnt + 1 : 0;
      rdy_cnt = ready_n_in ? 0 : rdy_cnt + 1;
      hold_cnt = hold_n_in ? hold_cnt + 1 : 0;
      grant_age = grant_age + 1;
      str_prev = str_low;
      cs_prev = cs_act;
      grant_prev = hold_grant_out;
      bus_request_out_prev = bus_request_out_n;
   end
endmodule : ext_bus_ready_and_hold_arbitration_bench
